// ---- verilog/tipc_ctrl.sv ----
// Touch attention line, power states and I2C register slave
`timescale 1ns/10ps
module tipc_ctrl
  import tipc_pkg::*;
#(
  parameter int         CLK_HZ        = CLK_HZ_D,
  parameter int         IDLE_TICK_CYC = IDLE_TICK_CYC_D,
  parameter logic [6:0] SLAVE_ADDR    = SLAVE_ADDR_D
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       irq_i,
  output logic            irq_o,
  output logic            irq_oe,
  input  wire logic       scan_done,
  input  wire logic       finger_touch,
  input  wire logic       finger_moving,
  input  wire logic [2:0] finger_count,
  output logic            scan_start,
  output logic            scan_clk_run,
  output logic [1:0]      power_state
);

  // Core-domain state
  typedef struct packed {
    logic [1:0]  pstate;
    logic        auto_doze;
    logic [3:0]  cfg;
    logic [7:0]  doze_rate;
    logic [7:0]  idle_to;
    logic [2:0]  st_s;
    logic [2:0]  sp_s;
    logic [2:0]  wr_s;
    logic [2:0]  rp_s;
    logic [2:0]  pin_s;
    logic        busy;
    logic [2:0]  snap_cnt;
    logic [1:0]  snap_pwr;
    logic        kick;
    logic [31:0] rate_acc;
    logic [31:0] tick_cnt;
    logic [7:0]  idle_units;
    logic        was_touch;
    logic        pending;
    logic        level;
    logic [4:0]  pulse_cnt;
    logic        scan_start;
    logic        clk_run;
    logic        irq_o;
    logic        irq_oe;
  } tipc_core_t;

  // Link-domain state, rising SCL
  typedef struct packed {
    tipc_lstate_t state;
    logic [2:0]   cnt;
    logic [7:0]   sh;
    logic [7:0]   ptr;
    logic [7:0]   tx;
    logic [7:0]   wr_addr;
    logic [7:0]   wr_data;
    logic         rw;
    logic         st_seen;
    logic         wr_tgl;
    logic         rp_tgl;
  } tipc_link_t;

  // Link-domain drive state, falling SCL
  typedef struct packed {
    logic drive_low;
    logic lvl;
  } tipc_drv_t;

  tipc_core_t r_reg, r_next;
  tipc_link_t l_reg, l_next;
  tipc_drv_t  d_reg, d_next;
  logic       st_tgl_reg;
  logic       sp_tgl_reg;

  // Read mux; snapshot values feeding it only change outside transfers, written fields change mid-transfer on writes
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input tipc_core_t c);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      REG_REPORT:    v = {5'h00, c.snap_cnt};
      REG_POWER:     v = {5'h00, c.auto_doze, c.snap_pwr};
      REG_IRQ_CFG:   v = {4'h0, c.cfg};
      REG_DOZE_RATE: v = c.doze_rate;
      REG_IDLE_TO:   v = c.idle_to;
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // Start and stop seen as SDA edges while SCL is high
  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) st_tgl_reg <= 1'b0;
    else if (scl) st_tgl_reg <= ~st_tgl_reg;
  end

  always_ff @(posedge sda_i or negedge rst_n) begin
    if (!rst_n) sp_tgl_reg <= 1'b0;
    else if (scl) sp_tgl_reg <= ~sp_tgl_reg;
  end

  // Byte engine on rising SCL
  always_comb begin
    l_next = l_reg;
    l_next.st_seen = st_tgl_reg;
    if (st_tgl_reg != l_reg.st_seen) begin
      l_next.state = LS_ADDR;
      l_next.cnt   = 3'h1;
      l_next.sh    = {7'h00, sda_i};
    end else begin
      case (l_reg.state)
        LS_ADDR: begin
          l_next.sh  = {l_reg.sh[6:0], sda_i};
          l_next.cnt = l_reg.cnt + 3'h1;
          if (l_reg.cnt == 3'h7) begin
            l_next.rw    = sda_i;
            l_next.state = (l_next.sh[7:1] == SLAVE_ADDR) ? LS_AACK : LS_IDLE;
          end
        end
        LS_AACK: begin
          l_next.cnt = 3'h0;
          if (l_reg.rw) begin
            l_next.state = LS_TX;
            l_next.tx    = rd_byte(l_reg.ptr, r_reg);
            if (l_reg.ptr == REG_REPORT) l_next.rp_tgl = ~l_reg.rp_tgl;
          end else begin
            l_next.state = LS_PTR;
          end
        end
        LS_PTR: begin
          l_next.sh  = {l_reg.sh[6:0], sda_i};
          l_next.cnt = l_reg.cnt + 3'h1;
          if (l_reg.cnt == 3'h7) begin
            l_next.ptr   = l_next.sh;
            l_next.state = LS_DACK;
          end
        end
        LS_WDATA: begin
          l_next.sh  = {l_reg.sh[6:0], sda_i};
          l_next.cnt = l_reg.cnt + 3'h1;
          if (l_reg.cnt == 3'h7) begin
            l_next.wr_addr = l_reg.ptr;
            l_next.wr_data = l_next.sh;
            l_next.wr_tgl  = ~l_reg.wr_tgl;
            l_next.ptr     = l_reg.ptr + 8'h01;
            l_next.state   = LS_DACK;
          end
        end
        LS_DACK: begin
          l_next.cnt   = 3'h0;
          l_next.state = LS_WDATA;
        end
        LS_TX: begin
          l_next.tx  = {l_reg.tx[6:0], 1'b0};
          l_next.cnt = l_reg.cnt + 3'h1;
          if (l_reg.cnt == 3'h7) l_next.state = LS_MACK;
        end
        LS_MACK: begin
          l_next.cnt = 3'h0;
          if (!sda_i) begin
            l_next.state = LS_TX;
            l_next.tx    = rd_byte(l_reg.ptr, r_reg);
          end else begin
            l_next.state = LS_IDLE;
          end
        end
        default: l_next.state = LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) l_reg <= '{state: LS_IDLE, default: '0};
    else l_reg <= l_next;
  end

  // SDA pull-down changes on falling SCL only
  always_comb begin
    d_next.lvl       = 1'b0;
    d_next.drive_low = (l_reg.state == LS_AACK) || (l_reg.state == LS_DACK) ||
                       ((l_reg.state == LS_TX) && !l_reg.tx[7]);
  end

  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) d_reg <= '0;
    else d_reg <= d_next;
  end

  // Core next-state logic
  always_comb begin
    logic ev_start, ev_stop, ev_wr, ev_rpt, ev_pin;
    logic scan_ok, lift, pend_eff, svc, fire, en;
    logic [1:0] mode;
    logic [31:0] acc;
    ev_start = 1'b0;
    ev_stop  = 1'b0;
    ev_wr    = 1'b0;
    ev_rpt   = 1'b0;
    ev_pin   = 1'b0;
    scan_ok  = 1'b0;
    lift     = 1'b0;
    pend_eff = 1'b0;
    svc      = 1'b0;
    fire     = 1'b0;
    en       = r_reg.cfg[IRQ_EN_BIT];
    mode     = r_reg.cfg[1:0];
    acc      = 32'h0;
    r_next   = r_reg;
    r_next.scan_start = 1'b0;

    // Two-flop crossings, then edge of the second flop
    r_next.st_s  = {r_reg.st_s[1:0], st_tgl_reg};
    r_next.sp_s  = {r_reg.sp_s[1:0], sp_tgl_reg};
    r_next.wr_s  = {r_reg.wr_s[1:0], l_reg.wr_tgl};
    r_next.rp_s  = {r_reg.rp_s[1:0], l_reg.rp_tgl};
    r_next.pin_s = {r_reg.pin_s[1:0], irq_i};
    ev_start = r_reg.st_s[1] ^ r_reg.st_s[2];
    ev_stop  = r_reg.sp_s[1] ^ r_reg.sp_s[2];
    ev_wr    = r_reg.wr_s[1] ^ r_reg.wr_s[2];
    ev_rpt   = r_reg.rp_s[1] ^ r_reg.rp_s[2];
    ev_pin   = r_reg.pin_s[1] ^ r_reg.pin_s[2];

    // Freeze read values while a transfer runs
    if (ev_start) r_next.busy = 1'b1;
    else if (ev_stop) r_next.busy = 1'b0;
    if (!r_reg.busy && !ev_start) begin
      r_next.snap_cnt = finger_count;
      r_next.snap_pwr = r_reg.pstate;
    end

    // Touch tracking and no-touch acknowledge, set wins
    scan_ok  = scan_done && (r_reg.pstate != PWR_FREEZE);
    lift     = scan_ok && r_reg.was_touch && !finger_touch;
    pend_eff = r_reg.pending || lift;
    svc      = ev_rpt && !finger_touch;
    if (scan_ok) r_next.was_touch = finger_touch;
    if (lift) r_next.pending = 1'b1;
    else if (svc) r_next.pending = 1'b0;

    // Trigger selection
    if (scan_ok && en) begin
      case (mode)
        TRIG_PERIODIC: fire = 1'b1;
        TRIG_MOVE:     fire = (finger_touch && finger_moving) || pend_eff;
        TRIG_PULSE:    fire = finger_touch || pend_eff;
        default:       fire = 1'b0;
      endcase
    end
    if (!en || mode != TRIG_LEVEL) r_next.level = 1'b0;
    else if (scan_ok && (finger_touch || pend_eff)) r_next.level = 1'b1;
    else if (svc) r_next.level = 1'b0;
    if (fire) r_next.pulse_cnt = IRQ_PULSE_CYC;
    else if (r_reg.pulse_cnt != 5'h00) r_next.pulse_cnt = r_reg.pulse_cnt - 5'h01;

    // Power state: hardware moves first, host write overrides
    r_next.clk_run = (r_reg.pstate != PWR_FREEZE);
    case (r_reg.pstate)
      PWR_ACTIVE: begin
        if (r_reg.kick || ev_stop ||
            (scan_ok && !fire && !(r_next.level && !r_reg.level))) begin
          r_next.scan_start = 1'b1;
          r_next.kick       = 1'b0;
        end
        if (scan_ok && finger_touch) begin
          r_next.tick_cnt   = 32'h0;
          r_next.idle_units = 8'h00;
        end else if (r_reg.tick_cnt >= 32'(IDLE_TICK_CYC - 1)) begin
          r_next.tick_cnt = 32'h0;
          if (r_reg.idle_units != 8'hff) r_next.idle_units = r_reg.idle_units + 8'h01;
        end else begin
          r_next.tick_cnt = r_reg.tick_cnt + 32'h1;
        end
        if (r_reg.auto_doze && r_reg.idle_units > r_reg.idle_to)
          r_next.pstate = PWR_SLEEP;
      end
      PWR_SLEEP: begin
        acc = r_reg.rate_acc + 32'((r_reg.doze_rate == 8'h00) ? DOZE_RATE_RST : r_reg.doze_rate);
        if (acc >= 32'(CLK_HZ)) begin
          r_next.scan_start = 1'b1;
          acc = acc - 32'(CLK_HZ);
        end
        r_next.rate_acc = acc;
        if (scan_ok && finger_touch) begin
          r_next.pstate = PWR_ACTIVE;
          r_next.kick   = 1'b1;
        end
      end
      PWR_FREEZE: begin
        if (ev_pin) begin
          r_next.pstate = PWR_ACTIVE;
          r_next.kick   = 1'b1;
        end
      end
      default: r_next.pstate = PWR_ACTIVE;
    endcase
    if (r_next.pstate != PWR_ACTIVE) begin
      r_next.tick_cnt   = 32'h0;
      r_next.idle_units = 8'h00;
    end
    if (r_next.pstate != PWR_SLEEP) r_next.rate_acc = 32'h0;

    // Register writes from the link
    if (ev_wr) begin
      case (l_reg.wr_addr)
        REG_POWER: begin
          r_next.auto_doze = l_reg.wr_data[PWR_AUTO_BIT];
          if (l_reg.wr_data[1:0] != PWR_INVALID) begin
            r_next.pstate = l_reg.wr_data[1:0];
            r_next.kick   = (l_reg.wr_data[1:0] == PWR_ACTIVE);
          end
        end
        REG_IRQ_CFG:   r_next.cfg       = l_reg.wr_data[3:0];
        REG_DOZE_RATE: r_next.doze_rate = l_reg.wr_data;
        REG_IDLE_TO:   r_next.idle_to   = l_reg.wr_data;
        default:       r_next.cfg       = r_next.cfg;
      endcase
    end

    // Attention pin: released in freeze so the host may toggle it
    r_next.irq_oe = (r_next.pstate != PWR_FREEZE);
    r_next.irq_o  = ((r_next.pulse_cnt != 5'h00) || r_next.level) ^
                    ~r_next.cfg[IRQ_POL_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg           <= '0;
      r_reg.cfg       <= IRQ_CFG_RST;
      r_reg.auto_doze <= AUTO_DOZE_RST;
      r_reg.doze_rate <= DOZE_RATE_RST;
      r_reg.idle_to   <= IDLE_TO_RST;
      r_reg.pstate    <= PWR_ACTIVE;
      r_reg.kick      <= 1'b1;
      r_reg.irq_o     <= 1'b1;
      r_reg.pin_s     <= 3'h7; // Pin idles high, no false edge after reset
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign sda_o        = d_reg.lvl;
  assign sda_oe       = d_reg.drive_low;
  assign irq_o        = r_reg.irq_o;
  assign irq_oe       = r_reg.irq_oe;
  assign scan_start   = r_reg.scan_start;
  assign scan_clk_run = r_reg.clk_run;
  assign power_state  = r_reg.pstate;

  // Checks
  sequence s_att_pulse;
    (r_reg.pulse_cnt != 5'h00) [*8];
  endsequence

  a_addr_ack: assert property (@(posedge scl) disable iff (!rst_n)
    (l_reg.state == LS_AACK) |-> sda_oe)
    else $error("address not acknowledged");

  a_pol_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r_reg.pulse_cnt == 5'h00 && !r_reg.level) |-> (irq_o == !r_reg.cfg[IRQ_POL_BIT]))
    else $error("idle attention level wrong");

  a_periodic_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (scan_done && r_reg.cfg == 4'h8 && r_reg.pstate != PWR_FREEZE) |=> s_att_pulse)
    else $error("periodic pulse missing");

  a_level_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r_reg.level && r_reg.cfg[3] && r_reg.cfg[1:0] == TRIG_LEVEL &&
     !(r_reg.rp_s[1] ^ r_reg.rp_s[2]) && !(r_reg.wr_s[1] ^ r_reg.wr_s[2])) |=> r_reg.level)
    else $error("level released early");

  a_scan_after_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r_reg.pstate == PWR_ACTIVE && (r_reg.sp_s[1] ^ r_reg.sp_s[2]) &&
     !(r_reg.wr_s[1] ^ r_reg.wr_s[2])) |=> scan_start)
    else $error("no scan after transfer");

  a_sleep_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r_reg.pstate == PWR_SLEEP && scan_done && finger_touch &&
     !(r_reg.wr_s[1] ^ r_reg.wr_s[2])) |=> (power_state == PWR_ACTIVE) ##1 scan_start)
    else $error("touch did not wake");

  a_no_self_doze: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r_reg.pstate == PWR_ACTIVE && !r_reg.auto_doze && !(r_reg.wr_s[1] ^ r_reg.wr_s[2]))
    |=> (power_state == PWR_ACTIVE))
    else $error("demoted without permission");

  a_freeze_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r_reg.pstate == PWR_FREEZE && $past(r_reg.pstate) == PWR_FREEZE)
    |-> (!scan_clk_run && !scan_start && !irq_oe))
    else $error("activity in freeze");

endmodule // tipc_ctrl

// ---- verilog/tipc_pkg.sv ----
// Constants and types for the touch attention and power-state controller
package tipc_pkg;

  // Register offsets
  localparam logic [7:0] REG_REPORT    = 8'h00;
  localparam logic [7:0] REG_POWER     = 8'h33;
  localparam logic [7:0] REG_IRQ_CFG   = 8'h34;
  localparam logic [7:0] REG_DOZE_RATE = 8'h35;
  localparam logic [7:0] REG_IDLE_TO   = 8'h36;

  // Field positions
  localparam int IRQ_EN_BIT   = 3;
  localparam int IRQ_POL_BIT  = 2;
  localparam int PWR_AUTO_BIT = 2;

  // Trigger and power codes
  localparam logic [1:0] TRIG_PERIODIC = 2'h0;
  localparam logic [1:0] TRIG_MOVE     = 2'h1;
  localparam logic [1:0] TRIG_LEVEL    = 2'h2;
  localparam logic [1:0] TRIG_PULSE    = 2'h3;
  localparam logic [1:0] PWR_ACTIVE    = 2'h0;
  localparam logic [1:0] PWR_SLEEP     = 2'h1;
  localparam logic [1:0] PWR_INVALID   = 2'h2;
  localparam logic [1:0] PWR_FREEZE    = 2'h3;

  // Values after reset
  localparam logic [3:0] IRQ_CFG_RST   = 4'h9;
  localparam logic       AUTO_DOZE_RST = 1'b0;
  localparam logic [7:0] DOZE_RATE_RST = 8'h0a;
  localparam logic [7:0] IDLE_TO_RST   = 8'h0a;

  // Timing
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         IRQ_PULSE_NS    = 1000;
  localparam logic [4:0] IRQ_PULSE_CYC   =
    5'((IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int         IDLE_TICK_MS    = 100;
  localparam int         IDLE_TICK_CYC_D = IDLE_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         CLK_HZ_D        = 1000000000 / CLK_PERIOD_NS;

  // Bus address, arbitrary value
  localparam logic [6:0] SLAVE_ADDR_D = 7'h2a;

  // Link-side byte engine states
  typedef enum logic [7:0] {
    LS_IDLE  = 8'h01,
    LS_ADDR  = 8'h02,
    LS_AACK  = 8'h04,
    LS_PTR   = 8'h08,
    LS_WDATA = 8'h10,
    LS_DACK  = 8'h20,
    LS_TX    = 8'h40,
    LS_MACK  = 8'h80
  } tipc_lstate_t;

endpackage

// ---- verif/tipc_host_model.sv ----
// Host model: I2C master for the controller's register port
`timescale 1ns/10ps
module tipc_host_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  logic       addr_ack;
  logic [7:0] rd_byte;
  event       rd_done;

  // Bus idle, both lines released
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    addr_ack = 1'b0;
    rd_byte  = 8'h00;
  end

  // Drive one bit, change only while scl is low
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask

  // Sample one bit in mid high phase
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 b = sda;
    #16 scl = 1'b0;
    #16;
  endtask

  // Start or repeated start
  task automatic start_c();
    sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask

  // Stop, then scl rests high
  task automatic stop_c();
    sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #32;
  endtask

  // Byte out MSB first, ninth bit is the acknowledge
  task automatic send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask

  // Pointer then one data byte
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic k;
    start_c();
    send({a, 1'b0}, addr_ack);
    send(p, k);
    send(d, k);
    stop_c();
  endtask

  // Pointer write, then one byte read with a closing nack
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p);
    logic k;
    logic b;
    start_c();
    send({a, 1'b0}, addr_ack);
    send(p, k);
    stop_c();
    start_c();
    send({a, 1'b1}, k);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      rd_byte[i] = b;
    end
    put_bit(1'b1);
    stop_c();
    -> rd_done;
  endtask
endmodule // tipc_host_model

// ---- verif/testbench.sv ----
// Self-checking bench for the attention and power-state controller
`timescale 1ns/10ps
module testbench
  import tipc_pkg::*;
;
  localparam int HZ = 1000;

  logic       core_clk;
  logic       rst_n;
  logic       scl;
  logic       sda_pull;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe;
  logic       irq_w;
  logic       irq_o;
  logic       irq_oe;
  logic       host_irq;
  logic       scan_done;
  logic       finger_touch;
  logic       finger_moving;
  logic [2:0] finger_count;
  logic       scan_start;
  logic       scan_clk_run;
  logic [1:0] power_state;
  logic [7:0] exp_q[$];
  int         num_errors;
  int         num_checks;
  int         starts = 0;
  int         base;

  // Open-drain SDA with pull-up; attention wire driven by the controller, or by the host when released
  assign sda_w = ~((sda_oe & ~sda_o) | sda_pull);
  assign irq_w = irq_oe ? irq_o : host_irq;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  tipc_ctrl #(.CLK_HZ(HZ), .IDLE_TICK_CYC(20)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq_i(irq_w), .irq_o(irq_o),
    .irq_oe(irq_oe), .scan_done(scan_done), .finger_touch(finger_touch),
    .finger_moving(finger_moving), .finger_count(finger_count),
    .scan_start(scan_start), .scan_clk_run(scan_clk_run),
    .power_state(power_state)
  );

  tipc_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));

  // Counts scan requests
  always @(posedge core_clk) begin
    if (scan_start === 1'b1) starts <= starts + 1;
  end

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic chk_val(input string w, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    chk_val("read data", e, g);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Read byte checker, oldest expectation first
  initial begin
    forever begin
      @(host.rd_done);
      chk_byte(exp_q.pop_front(), host.rd_byte);
    end
  end

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.write_reg(SLAVE_ADDR_D, p, d);
    cyc(4);
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    host.read_reg(SLAVE_ADDR_D, p);
    cyc(6);
  endtask

  task automatic wait_state(input logic [1:0] s, input int lim);
    int n;
    n = 0;
    while (power_state !== s && n < lim) begin
      cyc();
      n++;
    end
    chk_val("power state", 8'(s), 8'(power_state));
    if (power_state !== s) tally_and_finish();
  endtask

  // One finished scan from the sensing side
  task automatic scan(input logic t, input logic m);
    finger_touch  = t;
    finger_moving = m;
    scan_done     = 1'b1;
    cyc();
    scan_done     = 1'b0;
  endtask

  // Scan, then count cycles at the asserted level
  task automatic step(input logic t, input logic m, input logic lvl, input int e);
    int n;
    n = 0;
    scan(t, m);
    // First sample is the edge that took the scan
    repeat (45) begin
      if (irq_o === lvl) n++;
      cyc();
    end
    chk_val("attention cycles", 8'(e), 8'(n));
  endtask

  initial begin
    rst_n = 1'b0;
    host_irq = 1'b1;
    scan_done = 1'b0;
    finger_touch = 1'b0;
    finger_moving = 1'b0;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(35957));
    finger_count = 3'($urandom_range(7, 1));
    cyc(6);
    chk_val("idle attention", 8'h01, 8'(irq_o));
    rst_n = 1'b1;
    cyc(2);
    chk_val("attention drive", 8'h01, 8'(irq_oe));
    rd(REG_IRQ_CFG, {4'h0, IRQ_CFG_RST});
    rd(REG_POWER, 8'h00);
    rd(REG_DOZE_RATE, DOZE_RATE_RST);
    rd(REG_IDLE_TO, IDLE_TO_RST);
    rd(8'h50, 8'h00);
    host.write_reg(SLAVE_ADDR_D ^ 7'h01, REG_IRQ_CFG, 8'h00);
    cyc(4);
    chk_val("foreign address ack", 8'h00, 8'(host.addr_ack));
    rd(REG_IRQ_CFG, {4'h0, IRQ_CFG_RST});
    $display("test registers finished");
    base = starts;
    wr(REG_IRQ_CFG, 8'h08);
    cyc(8);
    chk_val("scan after transfer", 8'h01, 8'(starts != base));
    step(1'b0, 1'b0, 1'b0, 20);
    wr(REG_IRQ_CFG, 8'h0d);
    step(1'b1, 1'b1, 1'b1, 20);
    step(1'b1, 1'b0, 1'b1, 0);
    step(1'b0, 1'b0, 1'b1, 20);
    step(1'b0, 1'b0, 1'b1, 20);
    rd(REG_REPORT, {5'h00, finger_count});
    step(1'b0, 1'b0, 1'b1, 0);
    wr(REG_IRQ_CFG, 8'h0a);
    step(1'b1, 1'b0, 1'b0, 45);
    step(1'b0, 1'b0, 1'b0, 45);
    rd(REG_REPORT, {5'h00, finger_count});
    chk_val("released attention", 8'h01, 8'(irq_o));
    wr(REG_IRQ_CFG, 8'h0f);
    step(1'b1, 1'b0, 1'b1, 20);
    step(1'b0, 1'b0, 1'b1, 20);
    rd(REG_REPORT, {5'h00, finger_count});
    step(1'b0, 1'b0, 1'b1, 0);
    wr(REG_IRQ_CFG, 8'h01);
    step(1'b1, 1'b1, 1'b0, 0);
    rd(REG_IRQ_CFG, 8'h01);
    $display("test attention finished");
    wr(REG_POWER, 8'h01);
    wait_state(PWR_SLEEP, 10);
    wr(REG_POWER, 8'h02);
    chk_val("refused code", 8'(PWR_SLEEP), 8'(power_state));
    // Rate 0 falls back to the reset rate
    for (int r = 0; r <= 20; r += 10) begin
      int rate;
      rate = (r == 0) ? int'(DOZE_RATE_RST) : r;
      wr(REG_DOZE_RATE, 8'(r));
      cyc(150);
      base = starts;
      cyc(400);
      chk_val("doze scans", 8'(rate * 400 / HZ), 8'(starts - base));
    end
    scan(1'b1, 1'b0);
    wait_state(PWR_ACTIVE, 10);
    wr(REG_IDLE_TO, 8'h02);
    cyc(200);
    chk_val("no demotion", 8'(PWR_ACTIVE), 8'(power_state));
    wr(REG_POWER, 8'h04);
    wait_state(PWR_SLEEP, 100);
    scan(1'b1, 1'b0);
    wait_state(PWR_ACTIVE, 10);
    cyc(30);
    chk_val("early demotion", 8'(PWR_ACTIVE), 8'(power_state));
    wait_state(PWR_SLEEP, 80);
    wr(REG_POWER, 8'h00);
    wait_state(PWR_ACTIVE, 10);
    $display("test power finished");
    wr(REG_POWER, 8'h03);
    wait_state(PWR_FREEZE, 10);
    chk_val("scan clock", 8'h00, 8'(scan_clk_run));
    chk_val("attention drive", 8'h00, 8'(irq_oe));
    base = starts;
    scan(1'b1, 1'b1);
    cyc(50);
    chk_val("frozen scans", 8'h00, 8'(starts - base));
    host_irq = 1'b0;
    wait_state(PWR_ACTIVE, 10);
    host_irq = 1'b1;
    cyc(5);
    chk_val("scan after wake", 8'h01, 8'(starts != base));
    wr(REG_POWER, 8'h03);
    wait_state(PWR_FREEZE, 10);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    chk_val("reset wake", 8'(PWR_ACTIVE), 8'(power_state));
    rd(REG_IRQ_CFG, {4'h0, IRQ_CFG_RST});
    $display("test freeze finished");
    tally_and_finish();
  end
endmodule // testbench
